// File: hdl/pcrc_pkg.sv
// Overview of operation
// - Seed-select set: every data-register write loads the accumulator as a seed.
// - Seed-select clear: every data-register write is folded into the running CRC.
// - 16-bit mode: upper two data bytes ignored when loading a seed.
// - 32-bit mode: all four written bytes form the seed.
// - Data written as 8, 16 or 32 bits; most significant byte processed first.
// - Checksum sits in low two bytes in 16-bit mode, all four in 32-bit.
// - Any data-register read returns the current intermediate CRC.
// - With seed-select clear, upper data bytes enter the CRC in both modes.
// - Upper polynomial half writable and used only in 32-bit mode.
// - Lower polynomial half readable, writable and used in both modes.
// - Width-select 1 means 32-bit mode, 0 means 16-bit mode.
// - Set seed-select, then write the seed; the accumulator restarts from it.
// - Data register at 0x0, polynomial at 0x4, control at 0x8.
// - Control bits 31:30 select the transpose applied to written data.
// - Control bits 29:28 select the transpose applied to data-register reads.
// - Control bit 26 set complements data-register reads.
// - Seed-select is control bit 25, width-select is control bit 24.
package pcrc_pkg;

	// Register offsets
	localparam int unsigned PCRC_AW = 12;
	localparam logic [11:0] PCRC_OFS_VALUE = 12'h000;
	localparam logic [11:0] PCRC_OFS_POLY = 12'h004;
	localparam logic [11:0] PCRC_OFS_CTRL = 12'h008;

	// Values after reset
	localparam logic [31:0] PCRC_RST_VALUE = 32'hffffffff;
	localparam logic [31:0] PCRC_RST_POLY = 32'h00001021;
	localparam logic [31:0] PCRC_RST_CTRL = 32'h00000000;

	// Writable control bits: 31:28, 26, 25, 24
	localparam logic [31:0] PCRC_CTRL_WMASK = 32'hf7000000;

	// Transpose encodings
	localparam logic [1:0] PCRC_TR_NONE = 2'h0;
	localparam logic [1:0] PCRC_TR_BITS = 2'h1;
	localparam logic [1:0] PCRC_TR_BOTH = 2'h2;
	localparam logic [1:0] PCRC_TR_BYTES = 2'h3;

	// Control register layout
	typedef struct packed {
		logic [1:0] write_transpose_type;
		logic [1:0] read_transpose_type;
		logic rsvd27;
		logic read_complement_enable;
		logic seed_write_select;
		logic crc_width_select;
		logic [23:0] rsvd;
	} pcrc_ctrl_s;

	// Registered APB answer
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pcrc_apb_rsp_s;

	// Bit reversal within each byte
	function automatic logic [31:0] pcrc_bit_rev(input logic [31:0] d);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 4; i++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				r[i * 8 + b] = d[i * 8 + 7 - b];
			end
		end
		return r;
	endfunction : pcrc_bit_rev

	// Byte order reversal
	function automatic logic [31:0] pcrc_byte_rev(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction : pcrc_byte_rev

	// Transpose by type code
	function automatic logic [31:0] pcrc_transpose(input logic [31:0] d, input logic [1:0] t);
		logic [31:0] r;
		r = d;
		unique case (t)
			PCRC_TR_NONE: r = d;
			PCRC_TR_BITS: r = pcrc_bit_rev(d);
			PCRC_TR_BOTH: r = pcrc_byte_rev(pcrc_bit_rev(d));
			PCRC_TR_BYTES: r = pcrc_byte_rev(d);
		endcase
		return r;
	endfunction : pcrc_transpose

	// Byte strobes to bit mask
	function automatic logic [31:0] pcrc_strb_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : pcrc_strb_mask

endpackage : pcrc_pkg

// File: hdl/pcrc_byte_step.sv
`timescale 1ns/10ps
module pcrc_byte_step
	import pcrc_pkg::*;
(
	// Accumulator in and out
	input wire logic [31:0] crc_i,
	output logic [31:0] crc_o,
	// Message byte and settings
	input wire logic [7:0] data_i,
	input wire logic [31:0] poly_i,
	input wire logic width_32_i
);

	logic [31:0] c32;
	logic [15:0] c16;

	// Eight LFSR shifts, message MSB first
	always_comb
	begin
		c32 = crc_i ^ {data_i, 24'h000000};
		c16 = crc_i[15:0] ^ {data_i, 8'h00};
		for (int b = 0; b < 8; b++)
		begin
			c32 = c32[31] ? ({c32[30:0], 1'b0} ^ poly_i) : {c32[30:0], 1'b0};
			c16 = c16[15] ? ({c16[14:0], 1'b0} ^ poly_i[15:0]) : {c16[14:0], 1'b0};
		end
	end

	assign crc_o = width_32_i ? c32 : {crc_i[31:16], c16};

endmodule : pcrc_byte_step

// File: hdl/pcrc_core.sv
`timescale 1ns/10ps
module pcrc_core
	import pcrc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// APB request
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [PCRC_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	// APB answer
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);

	// Registers
	logic [31:0] value_r;
	logic [31:0] value_nxt;
	logic [31:0] poly_r;
	logic [31:0] poly_nxt;
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	pcrc_apb_rsp_s rsp_r;
	pcrc_apb_rsp_s rsp_nxt;

	// Control view
	pcrc_ctrl_s ctrl;
	assign ctrl = pcrc_ctrl_s'(ctrl_r);

	// Bus phase decode
	wire access_phase;
	wire xfer_done;
	wire hit_value;
	wire hit_poly;
	wire hit_ctrl;
	wire mapped;
	wire wr_value;
	wire wr_poly;
	wire wr_ctrl;

	assign access_phase = psel_i & penable_i;
	assign xfer_done = access_phase & rsp_r.pready;
	assign hit_value = (paddr_i == PCRC_OFS_VALUE);
	assign hit_poly = (paddr_i == PCRC_OFS_POLY);
	assign hit_ctrl = (paddr_i == PCRC_OFS_CTRL);
	assign mapped = hit_value | hit_poly | hit_ctrl;
	assign wr_value = xfer_done & pwrite_i & hit_value;
	assign wr_poly = xfer_done & pwrite_i & hit_poly;
	assign wr_ctrl = xfer_done & pwrite_i & hit_ctrl;

	// Write transpose of data and its lanes
	wire [31:0] wdata_t;
	wire [3:0] wstrb_t;

	assign wdata_t = pcrc_transpose(pwdata_i, ctrl.write_transpose_type);
	assign wstrb_t = ctrl.write_transpose_type[1]
		? {pstrb_i[0], pstrb_i[1], pstrb_i[2], pstrb_i[3]}
		: pstrb_i;

	// Seed merge per lane
	wire [31:0] seed_val;
	wire [3:0] seed_lane_en;

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_seed
			if (i < 2)
			begin : g_low
				assign seed_lane_en[i] = wstrb_t[i];
			end
			else
			begin : g_high
				assign seed_lane_en[i] = wstrb_t[i] & ctrl.crc_width_select;
			end
			assign seed_val[i * 8 +: 8] = seed_lane_en[i] ? wdata_t[i * 8 +: 8] : value_r[i * 8 +: 8];
		end
	endgenerate

	// Byte chain, highest lane first
	wire [31:0] stage_crc [0:4];
	wire [31:0] stage_out [0:3];

	assign stage_crc[0] = value_r;

	generate
		for (genvar k = 0; k < 4; k++)
		begin : g_chain
			pcrc_byte_step u_step (
				.crc_i(stage_crc[k]),
				.crc_o(stage_out[k]),
				.data_i(wdata_t[(3 - k) * 8 +: 8]),
				.poly_i(poly_r),
				.width_32_i(ctrl.crc_width_select)
			);
			assign stage_crc[k + 1] = wstrb_t[3 - k] ? stage_out[k] : stage_crc[k];
		end
	endgenerate

	// Accumulator next value
	always_comb
	begin
		value_nxt = value_r;
		if (wr_value)
		begin
			if (ctrl.seed_write_select)
			begin
				value_nxt = seed_val;
			end
			else
			begin
				value_nxt = stage_crc[4];
			end
		end
	end

	// Polynomial write, upper half only in 32-bit mode
	wire [31:0] poly_mask;

	assign poly_mask = pcrc_strb_mask(pstrb_i) & {{16{ctrl.crc_width_select}}, 16'hffff};

	always_comb
	begin
		poly_nxt = poly_r;
		if (wr_poly)
		begin
			poly_nxt = (poly_r & ~poly_mask) | (pwdata_i & poly_mask);
		end
	end

	// Control write, reserved bits held at zero
	wire [31:0] ctrl_mask;

	assign ctrl_mask = pcrc_strb_mask(pstrb_i) & PCRC_CTRL_WMASK;

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
		begin
			ctrl_nxt = (ctrl_r & ~ctrl_mask) | (pwdata_i & ctrl_mask);
		end
	end

	// Read data path
	wire [31:0] value_rd;
	wire [31:0] rdata_sel;

	assign value_rd = pcrc_transpose(value_r, ctrl.read_transpose_type)
		^ {32{ctrl.read_complement_enable}};
	assign rdata_sel = hit_value ? value_rd
		: hit_poly ? poly_r
		: hit_ctrl ? ctrl_r
		: 32'h00000000;

	// Answer one cycle into the access phase
	always_comb
	begin
		rsp_nxt.pready = access_phase & ~rsp_r.pready;
		rsp_nxt.pslverr = access_phase & ~rsp_r.pready & ~mapped;
		rsp_nxt.prdata = rsp_r.prdata;
		if (access_phase & ~rsp_r.pready & ~pwrite_i)
		begin
			rsp_nxt.prdata = rdata_sel;
		end
	end

	// State registers
	always_ff @(posedge sys_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			value_r <= PCRC_RST_VALUE;
			poly_r <= PCRC_RST_POLY;
			ctrl_r <= PCRC_RST_CTRL;
			rsp_r <= '0;
		end
		else
		begin
			value_r <= value_nxt;
			poly_r <= poly_nxt;
			ctrl_r <= ctrl_nxt;
			rsp_r <= rsp_nxt;
		end
	end

	assign prdata_o = rsp_r.prdata;
	assign pready_o = rsp_r.pready;
	assign pslverr_o = rsp_r.pslverr;

endmodule : pcrc_core

// File: testbench/pcrc_core_props.sv
`timescale 1ns/10ps
module pcrc_core_props
	import pcrc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// APB side
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [PCRC_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	default clocking
		@(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);
	wire logic map_w = paddr_i inside {12'h000, 12'h004, 12'h008};
	sequence s_setup;
		psel_i && !penable_i;
	endsequence : s_setup
	sequence s_acc;
		psel_i && penable_i && !pready_o;
	endsequence : s_acc
	property p_wait;
		s_setup ##1 s_acc |=> pready_o;
	endproperty : p_wait
	property p_pulse;
		pready_o |=> !pready_o;
	endproperty : p_pulse
	property p_inacc;
		pready_o |-> psel_i && penable_i;
	endproperty : p_inacc
	property p_err;
		pslverr_o |-> pready_o;
	endproperty : p_err
	property p_map;
		pready_o && map_w |-> !pslverr_o;
	endproperty : p_map
	property p_unmap;
		pready_o && !map_w |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
	endproperty : p_unmap
	property p_hold;
		!(pready_o && !pwrite_i) |-> $stable(prdata_o);
	endproperty : p_hold
	property p_rsvd;
		pready_o && !pwrite_i && paddr_i == 12'h008 |-> prdata_o[27] == 1'h0 && prdata_o[23:0] == 24'h0;
	endproperty : p_rsvd
	a_wait: assert property (p_wait)
		else $error("no answer one cycle into access");
	a_pulse: assert property (p_pulse)
		else $error("ready longer than one cycle");
	a_inacc: assert property (p_inacc)
		else $error("ready outside access phase");
	a_err: assert property (p_err)
		else $error("error without ready");
	a_map: assert property (p_map)
		else $error("error on mapped address");
	a_unmap: assert property (p_unmap)
		else $error("unmapped access not refused");
	a_hold: assert property (p_hold)
		else $error("read data changed without read");
	a_rsvd: assert property (p_rsvd)
		else $error("reserved control bits not zero");
endmodule : pcrc_core_props

// File: testbench/test_programmable_crc_register_core.sv
`timescale 1ns/10ps
module test_programmable_crc_register_core;
	import pcrc_pkg::*;
	localparam logic [31:0] FM = 32'hffffffff;
	localparam logic [31:0] LM = 32'h0000ffff;
	logic sys_clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic psel_i = 1'h0;
	logic penable_i = 1'h0;
	logic pwrite_i = 1'h0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [31:0] rd;
	logic rerr;
	int err_count = 0;
	int samples_checked = 0;
	logic [31:0] rx [4] = '{32'h0376e6e7, 32'hc06e67e7, 32'he7676ec0, 32'he7e67603};
	logic [31:0] wx [4] = '{32'h01020304, 32'h8040c020, 32'h20c04080, 32'h04030201};
	always #2.5 sys_clk_i = ~sys_clk_i;
	pcrc_core i_dut (.sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
		.prdata_o, .pready_o, .pslverr_o);
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge sys_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while (pready_o !== 1'h1 && n < 20);
		if (pready_o !== 1'h1)
		begin
			err_count++;
			end_of_test();
		end
		rd = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask : acc
	task wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'h1, a, d, 4'hf);
	endtask : wr
	task rc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'h0, a, 32'h0, 4'h0);
		chk(rd & m, e & m);
	endtask : rc
	// Message of nine ASCII digits
	task msg;
		wr(12'h000, 32'h31323334);
		wr(12'h000, 32'h35363738);
		acc(1'h1, 12'h000, 32'h00000039, 4'h1);
	endtask : msg
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		rstn_i <= 1'h1;
		rc(12'h000, FM, FM);
		rc(12'h004, 32'h00001021, FM);
		rc(12'h008, 32'h0, FM);
		wr(12'h004, 32'h12348005);
		rc(12'h004, 32'h00008005, FM);
		wr(12'h008, FM);
		rc(12'h008, 32'hf7000000, FM);
		acc(1'h0, 12'h00c, 32'h0, 4'h0);
		chk({31'h0, rerr}, 32'h1);
		acc(1'h1, 12'h00c, FM, 4'hf);
		chk({31'h0, rerr}, 32'h1);
		rc(12'h008, 32'hf7000000, FM);
		$display("registers done");
		wr(12'h008, 32'h02000000);
		wr(12'h004, 32'h00001021);
		wr(12'h000, 32'habcd1234);
		rc(12'h000, 32'h00001234, LM);
		wr(12'h000, LM);
		wr(12'h008, 32'h0);
		msg();
		rc(12'h000, 32'h000029b1, LM);
		$display("crc16 done");
		wr(12'h008, 32'h03000000);
		wr(12'h004, 32'h04c11db7);
		rc(12'h004, 32'h04c11db7, FM);
		wr(12'h000, FM);
		wr(12'h008, 32'h01000000);
		msg();
		for (int t = 0; t < 4; t++)
		begin
			wr(12'h008, {2'h0, 2'(t), 28'h1000000});
			rc(12'h000, rx[t], FM);
		end
		wr(12'h008, 32'h05000000);
		rc(12'h000, 32'hfc891918, FM);
		$display("crc32 done");
		for (int t = 0; t < 4; t++)
		begin
			wr(12'h008, {2'(t), 30'h03000000});
			wr(12'h000, 32'h01020304);
			rc(12'h000, wx[t], FM);
		end
		// Same message as partial writes, first two bytes byte-swapped
		wr(12'h000, FM);
		wr(12'h008, 32'hc1000000);
		acc(1'h1, 12'h000, 32'h00003231, 4'h3);
		wr(12'h008, 32'h01000000);
		acc(1'h1, 12'h000, 32'h33340000, 4'hc);
		wr(12'h000, 32'h35363738);
		acc(1'h1, 12'h000, 32'h00000039, 4'h1);
		rc(12'h000, rx[0], FM);
		$display("transpose done");
		// Reset in mid-run restores every register
		rstn_i <= 1'h0;
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'h1;
		rc(12'h000, FM, FM);
		rc(12'h004, 32'h00001021, FM);
		rc(12'h008, 32'h0, FM);
		$display("reset done");
		end_of_test();
	end
endmodule : test_programmable_crc_register_core
bind pcrc_core pcrc_core_props i_props (.sys_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o);
